/* pmf_core.sv */
// phase count, power state mode, slewing and fault supervision core
// assumes comparator results and straps arrive unsynchronised;
// registers reached over avalon-mm with waitrequest
//
// Contract
// - third phase pin strapped high selects two phases, pin 9 becomes feedback switch
// - third phase and second sense strapped high select one phase
// - mode from config and state inputs; state high, sleep low runs all
// - three-phase, both low: phases one and two, threshold two thirds
// - three-phase, sleep high: phase one diode emulation, threshold one third
// - two-phase, both low: phase one continuous, threshold one half
// - two-phase, sleep high: phase one diode emulation
// - one-phase ignores state input; sleep selects diode emulation
// - code change ramps at 5 mV/us, easing near target
// - diode emulation drives up, discontinuous after four zero crossings
// - diode emulation lets output decay on downward code change
// - fast dip of 20 mV issues an extra master clock
// - overcurrent declared after 120 us continuous excess
// - resistor band captured at start, held until enable or supply drops
// - way-overcurrent shuts pwm and power good within 2 us
// - sense imbalance over 9 mV for 1 ms latches fault
// - undervoltage 300 mV for 1 ms latches fault, pwm off
// - overvoltage 200 mV for 1 ms latches fault
// - faults drop power good, all switches off, cleared by enable or supply
// - above 1.55 V low sides on until below 0.85 V, repeats
// - absolute overvoltage armed when enabled, cleared by supply reset only
// - thermistor below 1.18 V pulls throttle low, nothing else
// - two-phase config closes feedback switch when two phases run
`timescale 1ns/1ps
`include "pmf_params.svh"
module pmf_core import pmf_pkg::*; #(
   parameter int OC_CYCLES = `PMF_OC_CYC,  // overcurrent qualification
   parameter int MS_CYCLES = `PMF_MS_CYC   // 1 ms qualification
) (
   input  wire logic        clock,               // 100 MHz
   input  wire logic        srst,                // sync reset
   input  wire logic        third_phase_strap,   // third phase pin held high
   input  wire logic        second_sense_strap,  // second sense held high
   input  wire logic        low_power_state_n,   // power state pin
   input  wire logic        deeper_sleep_request, // sleep pin
   input  wire logic        regulator_enable,    // enable above threshold
   input  wire logic        supply_ok,           // supply above por
   input  wire logic [6:0]  voltage_code,        // host code
   input  wire logic [2:0]  rcomp_band,          // resistor band, 0 none
   input  wire logic        oc_cmp,              // droop over threshold
   input  wire logic        woc_cmp,             // over 2.5x threshold
   input  wire logic        imb_cmp,             // sense spread over 9 mV
   input  wire logic        under_cmp,           // 300 mV under
   input  wire logic        ov1_cmp,             // 200 mV over
   input  wire logic        ova_hi_cmp,          // above 1.55 V
   input  wire logic        ova_lo_cmp,          // below 0.85 V
   input  wire logic        ntc_low_cmp,         // thermistor under 1.18 V
   input  wire logic        fast_dip_cmp,        // raw 20 mV under filtered
   input  wire logic        switch_cycle,        // toggles each cycle
   input  wire logic        zero_cross,          // current crossed zero
   input  wire logic [3:0]  address,             // avalon byte address
   input  wire logic        read,                // avalon read
   input  wire logic        write,               // avalon write
   input  wire logic [31:0] writedata,           // avalon write data
   output logic [31:0]      readdata,            // avalon read data
   output logic             waitrequest,         // avalon stall
   output logic [2:0]       phase_enable,        // phases switching
   output logic             diode_emulation,     // diode emulation mode
   output logic             discontinuous_conduction, // dcm
   output logic             drive_up,            // active up-slew in de
   output logic [11:0]      dac_level,           // reference, 0.5 mV
   output logic [15:0]      oc_threshold,        // 0.01 uA
   output logic [15:0]      woc_threshold,       // 0.01 uA
   output logic             aux_feedback_switch, // switch closed
   output logic             aux_feedback_track,  // node follows feedback
   output logic             extra_master_clock,  // one-cycle pulse
   output logic             pwm_tristate,        // all switches off
   output logic             low_side_force,      // low sides on
   output logic             power_good,          // power good
   output logic             thermal_throttle_n   // throttle, low active
);
   // ----------------------------------------
   // synchronisers
   // ----------------------------------------
   localparam int NS = 19;
   logic [NS-1:0] s1_q, s2_q;
   logic [NS-1:0] raw;
   assign raw = {voltage_code, third_phase_strap, second_sense_strap, low_power_state_n,
                 deeper_sleep_request, regulator_enable, supply_ok, oc_cmp, woc_cmp,
                 imb_cmp, under_cmp, ov1_cmp, ova_hi_cmp};
   logic [6:0] code_s;
   logic p3_s, i2_s, psi_s, dpr_s, en_s, por_s, oc_s, woc_s, imb_s, und_s, ov1_s, ovh_s;
   logic [5:0] e1_q, e2_q;
   logic ovl_s, ntc_s, dip_s, cyc_s, zc_s;
   always_ff @(posedge clock)
   begin
      s1_q <= raw;
      s2_q <= s1_q;
      e1_q <= {ova_lo_cmp, ntc_low_cmp, fast_dip_cmp, switch_cycle, zero_cross, 1'b0};
      e2_q <= e1_q;
   end
   assign {code_s, p3_s, i2_s, psi_s, dpr_s, en_s, por_s, oc_s, woc_s,
           imb_s, und_s, ov1_s, ovh_s} = s2_q;
   assign {ovl_s, ntc_s, dip_s, cyc_s, zc_s} = e2_q[5:1];
   // ----------------------------------------
   // start-up capture
   // ----------------------------------------
   logic        started_q;
   pmf_cfg_type cfg_q;
   logic [2:0]  band_q;
   logic        live;
   assign live = en_s & por_s;
   // band and straps held until enable or supply drops
   always_ff @(posedge clock)
   begin
      if (srst || !live)
      begin
         started_q <= 1'b0;
         cfg_q     <= PMF_CFG_3;
         band_q    <= 3'h0;
      end
      else if (!started_q)
      begin
         started_q <= 1'b1;
         band_q    <= rcomp_band_s();
         cfg_q     <= !p3_s ? PMF_CFG_3 : (i2_s ? PMF_CFG_1 : PMF_CFG_2);
      end
   end
   logic [2:0] band1_q, band2_q;
   always_ff @(posedge clock)
   begin
      band1_q <= rcomp_band;
      band2_q <= band1_q;
   end
   function automatic logic [2:0] rcomp_band_s();
      return band2_q;
   endfunction
   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   function automatic pmf_mode_type mode_of(pmf_cfg_type c, logic psi, logic dpr);
      pmf_mode_type m;
      m = pmf_mode_type'{phase_en: 3'h1, diode_em: 1'b0, nphase: 2'h1};
      if (dpr)
         m.diode_em = 1'b1;
      else if (c == PMF_CFG_3)
         m = psi ? pmf_mode_type'{3'h7, 1'b0, 2'h3} : pmf_mode_type'{3'h3, 1'b0, 2'h2};
      else if (c == PMF_CFG_2 && psi)
         m = pmf_mode_type'{3'h3, 1'b0, 2'h2};
      return m;
   endfunction
   function automatic logic [15:0] oc_lim_of(logic [2:0] b, logic [1:0] n);
      logic [127:0] col;
      col = n == 2'h3 ? `PMF_OCT_3PH : (n == 2'h2 ? `PMF_OCT_2PH : `PMF_OCT_1PH);
      return col[{b, 4'h0} +: 16];
   endfunction
   pmf_mode_type mode;
   assign mode = mode_of(cfg_q, psi_s, dpr_s);
   logic [15:0] thr;
   assign thr = oc_lim_of(band_q, mode.nphase);
   always_ff @(posedge clock)
   begin
      oc_threshold  <= thr;
      woc_threshold <= 16'(({2'h0, thr} * 18'h5) >> 1);
   end
   // ----------------------------------------
   // qualified faults
   // ----------------------------------------
   function automatic logic [`PMF_QCNT_W-1:0] qlim(int i);
      return `PMF_QCNT_W'(i == 0 ? OC_CYCLES - 1 : MS_CYCLES - 1);
   endfunction
   pmf_fault_type flt_q;
   logic [3:0]    qcond, qhit;
   assign qcond = {ov1_s, und_s, imb_s, oc_s};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_qual
         logic [`PMF_QCNT_W-1:0] cnt_q;
         always_ff @(posedge clock)
         begin
            if (srst || !started_q || !qcond[gi])
               cnt_q <= '0;
            else if (cnt_q != qlim(gi))
               cnt_q <= cnt_q + 1'b1;
         end
         assign qhit[gi] = qcond[gi] && cnt_q == qlim(gi);
      end
   endgenerate
   always_ff @(posedge clock)
   begin
      if (srst || !live)
         flt_q <= '0;
      else if (started_q)
         flt_q <= flt_q | {woc_s, qhit[3], qhit[2], qhit[1], qhit[0]};
   end
   // ----------------------------------------
   // absolute overvoltage
   // ----------------------------------------
   pmf_ova_type ova_q;
   logic        ova_flag_q;
   always_ff @(posedge clock)
   begin
      if (srst || !por_s)
      begin
         ova_q      <= PMF_OVA_IDLE;
         ova_flag_q <= 1'b0;
      end
      else
         case (ova_q)
            PMF_OVA_IDLE, PMF_OVA_OFF:
               if (en_s && ovh_s)
               begin
                  ova_q      <= PMF_OVA_CLAMP;
                  ova_flag_q <= 1'b1;
               end
            PMF_OVA_CLAMP:
               if (ovl_s)
                  ova_q <= PMF_OVA_OFF;
            default:
               ova_q <= PMF_OVA_IDLE;
         endcase
   end
   logic any_flt;
   assign any_flt = (|flt_q) | ova_flag_q;
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         power_good     <= 1'b0;
         pwm_tristate   <= 1'b1;
         low_side_force <= 1'b0;
         phase_enable   <= 3'h0;
      end
      else
      begin
         power_good     <= started_q && !any_flt;
         pwm_tristate   <= !started_q || any_flt;
         low_side_force <= ova_q == PMF_OVA_CLAMP;
         phase_enable   <= (started_q && !any_flt) ? mode.phase_en : 3'h0;
      end
   end
   always_ff @(posedge clock)
      thermal_throttle_n <= srst ? 1'b1 : !ntc_s;
   // ----------------------------------------
   // feedback switch
   // ----------------------------------------
   // closed while two phases run in the two-phase config only
   always_ff @(posedge clock)
   begin
      aux_feedback_switch <= !srst && cfg_q == PMF_CFG_2 && mode.nphase == 2'h2;
      aux_feedback_track  <= !srst && cfg_q == PMF_CFG_2;
   end
   // ----------------------------------------
   // reference slewing
   // ----------------------------------------
   logic [11:0] tgt;
   logic [4:0]  div_q;
   logic        near;
   assign tgt  = 12'(code_s * 12'(`PMF_CODE_STEP));
   assign near = (tgt > dac_level ? tgt - dac_level : dac_level - tgt) <= 12'(`PMF_CODE_STEP);
   always_ff @(posedge clock)
   begin
      if (srst || !started_q)
      begin
         dac_level <= 12'h000;
         div_q     <= 5'h00;
      end
      else if (mode.diode_em && tgt < dac_level)
         dac_level <= tgt;
      else if (div_q >= 5'(near ? 2 * `PMF_SLEW_DIV - 1 : `PMF_SLEW_DIV - 1))
      begin
         div_q <= 5'h00;
         if (tgt > dac_level)
            dac_level <= dac_level + 12'h001;
         else if (tgt < dac_level)
            dac_level <= dac_level - 12'h001;
      end
      else
         div_q <= div_q + 5'h01;
   end
   // ----------------------------------------
   // diode emulation and dcm
   // ----------------------------------------
   logic       cyc_d_q;
   logic [2:0] zc_q;
   always_ff @(posedge clock)
   begin
      cyc_d_q         <= cyc_s;
      diode_emulation <= !srst && mode.diode_em;
      // drive up then back to diode emulation
      drive_up        <= !srst && mode.diode_em && tgt > dac_level;
   end
   always_ff @(posedge clock)
   begin
      if (srst || !mode.diode_em || drive_up)
         zc_q <= 3'h0;
      else if (cyc_s != cyc_d_q)
         zc_q <= !zc_s ? 3'h0 : (zc_q == `PMF_ZC_CYCLES ? zc_q : zc_q + 3'h1);
   end
   always_ff @(posedge clock)
      discontinuous_conduction <= !srst && zc_q == `PMF_ZC_CYCLES;
   // ----------------------------------------
   // registers and fast clock
   // ----------------------------------------
   logic [31:0] ctrl_q;
   logic        dip_d_q;
   always_ff @(posedge clock)
   begin
      dip_d_q <= dip_s;
      extra_master_clock <= !srst && dip_s && !dip_d_q && ctrl_q[`PMF_CTRL_FAST_BIT]
                            && started_q && !any_flt;
   end
   always_ff @(posedge clock)
   begin
      if (srst)
         waitrequest <= 1'b1;
      else
         waitrequest <= !((read || write) && waitrequest);
   end
   always_ff @(posedge clock)
   begin
      if (srst)
         ctrl_q <= `PMF_CTRL_RESET;
      else if (write && !waitrequest && address == `PMF_REG_CTRL)
         ctrl_q <= writedata;
   end
   always_ff @(posedge clock)
   begin
      if (srst)
         readdata <= 32'h0;
      else if (read && waitrequest)
         case (address)
            `PMF_REG_CTRL:   readdata <= ctrl_q;
            `PMF_REG_STATUS: readdata <= {12'h0, band_q, cfg_q, ova_q, ova_flag_q, flt_q,
                                          power_good, mode};
            `PMF_REG_THRESH: readdata <= {woc_threshold, oc_threshold};
            `PMF_REG_DAC:    readdata <= {20'h0, dac_level};
            default:         readdata <= 32'h0;
         endcase
   end
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   sequence s_clamp;
      ova_q == PMF_OVA_CLAMP ##1 low_side_force;
   endsequence
   property p_mode3;
      started_q && cfg_q == PMF_CFG_3 && !psi_s && !dpr_s && !any_flt |=> phase_enable == 3'h3;
   endproperty
   a_mode3: assert property (p_mode3) else $error("three-phase low state wrong");
   property p_sleep;
      started_q && dpr_s && !any_flt |=> phase_enable == 3'h1 && diode_emulation;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep mode wrong");
   property p_scale;
      band_q == 3'h0 && mode.nphase == 2'h2 |=> oc_threshold == 16'd4000;
   endproperty
   a_scale: assert property (p_scale) else $error("threshold scale wrong");
   property p_oc;
      qhit[0] && started_q && live |=> flt_q.oc ##1 !power_good && pwm_tristate;
   endproperty
   a_oc: assert property (p_oc) else $error("overcurrent not latched");
   property p_woc;
      started_q && live && woc_s |-> ##[1:2] !power_good && pwm_tristate;
   endproperty
   a_woc: assert property (p_woc) else $error("way-overcurrent slow");
   property p_ova;
      por_s && en_s && ovh_s && ova_q != PMF_OVA_CLAMP |=> s_clamp;
   endproperty
   a_ova: assert property (p_ova) else $error("overvoltage clamp missing");
   property p_ova_hold;
      ova_flag_q && por_s |=> ova_flag_q;
   endproperty
   a_ova_hold: assert property (p_ova_hold) else $error("overvoltage flag lost");
   property p_ntc;
      ntc_s |=> !thermal_throttle_n;
   endproperty
   a_ntc: assert property (p_ntc) else $error("throttle not low");
   property p_aux_sw;
      cfg_q == PMF_CFG_2 && mode.nphase == 2'h1 |=> !aux_feedback_switch;
   endproperty
   a_aux_sw: assert property (p_aux_sw) else $error("feedback switch closed");
   property p_bus;
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
   endproperty
   a_bus: assert property (p_bus) else $error("bus answer timing");
endmodule

/* pmf_host_model.sv */
// host side of the control core: strap levels and the stepping code
// assumes one clock shared with the core and srst active high
`timescale 1ns/1ps
module pmf_host_model import pmf_pkg::*; (
   input  wire logic        clock,              // block clock
   input  wire logic        srst,               // sync reset
   input  wire pmf_cfg_type cfg,                // board phase count
   input  wire logic [6:0]  target,             // wanted code
   output logic             third_phase_strap,  // pin held high
   output logic             second_sense_strap, // pin held high
   output logic [6:0]       voltage_code        // code to core
);
   logic [7:0] gap_q;
   assign third_phase_strap  = (cfg != PMF_CFG_3);
   assign second_sense_strap = (cfg == PMF_CFG_1);
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         gap_q        <= 8'h00;
         voltage_code <= target;
      end
      else if (gap_q == 8'hf9)
      begin
         gap_q <= 8'h00;
         if (voltage_code < target)
            voltage_code <= voltage_code + 7'h01;
         else if (voltage_code > target)
            voltage_code <= voltage_code - 7'h01;
      end
      else
         gap_q <= gap_q + 8'h01;
   end
endmodule

/* pmf_params.svh */
// constants of the phase/mode/fault control core
// assumes a 100 MHz block clock and a 32-bit register bus
`ifndef PMF_PARAMS_SVH
`define PMF_PARAMS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define PMF_CLK_MHZ       100
`define PMF_OC_QUAL_US    120
`define PMF_QUAL_MS       1
`define PMF_WOC_MAX_US    2
`define PMF_OC_CYC        (`PMF_OC_QUAL_US * `PMF_CLK_MHZ)
`define PMF_MS_CYC        (`PMF_QUAL_MS * 1000 * `PMF_CLK_MHZ)
`define PMF_WOC_CYC       (`PMF_WOC_MAX_US * `PMF_CLK_MHZ)
`define PMF_QCNT_W        17
// ----------------------------------------
// slewing: dac unit 0.5 mV, 5 mV/us, code step 12.5 mV
// ----------------------------------------
`define PMF_DAC_UNIT_UV   500
`define PMF_SLEW_UV_US    5000
`define PMF_CODE_STEP_UV  12500
`define PMF_SLEW_DIV      (`PMF_CLK_MHZ * `PMF_DAC_UNIT_UV / `PMF_SLEW_UV_US)
`define PMF_CODE_STEP     (`PMF_CODE_STEP_UV / `PMF_DAC_UNIT_UV)
`define PMF_ZC_CYCLES     3'h4
// ----------------------------------------
// overcurrent table, 0.01 uA, band 7 .. band 0
// ----------------------------------------
`define PMF_OCT_1PH {16'd1800,16'd2070,16'd2270,16'd2000,16'd1800,16'd2070,16'd2270,16'd2000}
`define PMF_OCT_2PH {16'd4400,16'd4270,16'd3870,16'd3733,16'd3600,16'd4130,16'd4530,16'd4000}
`define PMF_OCT_3PH {16'd6600,16'd6400,16'd5800,16'd5600,16'd5400,16'd6200,16'd6800,16'd6000}
// ----------------------------------------
// register map
// ----------------------------------------
`define PMF_REG_CTRL      4'h0
`define PMF_REG_STATUS    4'h4
`define PMF_REG_THRESH    4'h8
`define PMF_REG_DAC       4'hc
`define PMF_CTRL_FAST_BIT 0
`define PMF_CTRL_RESET    32'h0000_0001
`endif

/* pmf_pkg.sv */
// types of the phase/mode/fault control core
// assumes pmf_params.svh for all figures
package pmf_pkg;
   typedef enum logic [1:0] {
      PMF_CFG_1 = 2'b01,
      PMF_CFG_2 = 2'b10,
      PMF_CFG_3 = 2'b11
   } pmf_cfg_type;
   typedef enum logic [1:0] {
      PMF_OVA_IDLE  = 2'b00,
      PMF_OVA_CLAMP = 2'b01,
      PMF_OVA_OFF   = 2'b10
   } pmf_ova_type;
   typedef struct packed {
      logic [2:0] phase_en;
      logic       diode_em;
      logic [1:0] nphase;
   } pmf_mode_type;
   typedef struct packed {
      logic woc;
      logic ov1;
      logic uv;
      logic imb;
      logic oc;
   } pmf_fault_type;
endpackage

/* tb_top.sv */
// self-checking bench of the control core with a mode model
// assumes small qualification counts of 20 and 40 cycles
`timescale 1ns/1ps
module tb_top import pmf_pkg::*;;
   logic clock = 0, srst = 1, lp_n = 1, ds = 0, en = 0, sup = 0, ntc = 0, dip = 0;
   logic ova_hi = 0, ova_lo = 0, rd = 0, wr = 0, tps, sss, dem, dcon, dup, afs, aft, emc;
   logic tri_o, lsf, pg, tt_n, wreq;
   logic [4:0]  flt = 5'h00;
   logic [3:0]  adr = 4'h0;
   logic [31:0] wd = 32'h0, r, rdata, seed = 32'h12;
   logic [6:0]  tgt = 7'h40, vc;
   logic [2:0]  ph;
   logic [11:0] dac;
   logic [15:0] oct, woc;
   pmf_cfg_type cfg = PMF_CFG_3;
   int n_errors = 0, checked = 0, cyc = 0;
   pmf_host_model host_u (.clock(clock), .srst(srst), .cfg(cfg), .target(tgt),
      .third_phase_strap(tps), .second_sense_strap(sss), .voltage_code(vc));
   pmf_core #(.OC_CYCLES(20), .MS_CYCLES(40)) dut_u (.clock(clock), .srst(srst),
      .third_phase_strap(tps), .second_sense_strap(sss), .low_power_state_n(lp_n),
      .deeper_sleep_request(ds), .regulator_enable(en), .supply_ok(sup),
      .voltage_code(vc), .rcomp_band(3'h0), .oc_cmp(flt[0]), .woc_cmp(flt[4]),
      .imb_cmp(flt[1]), .under_cmp(flt[2]), .ov1_cmp(flt[3]), .ova_hi_cmp(ova_hi),
      .ova_lo_cmp(ova_lo), .ntc_low_cmp(ntc), .fast_dip_cmp(dip), .switch_cycle(cyc[3]),
      .zero_cross(1'b0), .address(adr), .read(rd), .write(wr), .writedata(wd),
      .readdata(rdata), .waitrequest(wreq), .phase_enable(ph), .diode_emulation(dem),
      .discontinuous_conduction(dcon), .drive_up(dup), .dac_level(dac),
      .oc_threshold(oct), .woc_threshold(woc), .aux_feedback_switch(afs),
      .aux_feedback_track(aft), .extra_master_clock(emc), .pwm_tristate(tri_o),
      .low_side_force(lsf), .power_good(pg), .thermal_throttle_n(tt_n));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   always #5 clock = ~clock;
   always @(posedge clock)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         n_errors++;
         end_sim();
      end
   end
   function automatic int xs();
      logic [31:0] x;
      x = seed;
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      seed = x;
      return int'(x[15:0]);
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      rd  <= !w;
      wr  <= w;
      adr <= a;
      wd  <= d;
      @(posedge clock);
      while (wreq !== 1'b0) @(posedge clock);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic restart(input pmf_cfg_type c);
      cfg  <= c;
      srst <= 1'b1;
      en   <= 1'b1;
      sup  <= 1'b1;
      tick(6);
      srst <= 1'b0;
      tick(10);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      int c, s, st, np, k, n, p;
      for (c = 1; c <= 3; c++)
      begin
         restart(pmf_cfg_type'(c[1:0]));
         st = xs() % 4;
         for (s = 0; s < 4; s++)
         begin
            k = (st + s) % 4;
            lp_n <= k[1];
            ds   <= k[0];
            tick(8);
            np = k[0] ? 1 : (c == 1 ? 1 : (k[1] ? c : c - 1));
            chk(ph, (1 << np) - 1);
            chk(dem, k[0]);
            chk(oct, 2000 * np);
            chk(woc, 5000 * np);
            chk(afs, (c == 2 && np == 2));
            chk(aft, (c == 2));
         end
      end
      $display("mode table done");
      restart(PMF_CFG_3);
      lp_n <= 1'b1;
      ds   <= 1'b0;
      bus(1'b0, 4'h0, 32'h0);
      chk(r, 32'h1);
      bus(1'b1, 4'h8, 32'hffff_ffff);
      bus(1'b0, 4'h8, 32'h0);
      chk(r, {16'd15000, 16'd6000});
      bus(1'b0, 4'h2, 32'h0);
      chk(r, 32'h0);
      for (k = 1; k >= 0; k--)
      begin
         bus(1'b1, 4'h0, k);
         dip <= 1'b1;
         n = 0;
         repeat (12)
         begin
            @(posedge clock);
            n += emc;
         end
         dip <= 1'b0;
         tick(4);
         chk(n, k);
      end
      $display("bus and fast clock done");
      p = tri_o;
      ntc <= 1'b1;
      tick(6);
      chk(tt_n, 1'b0);
      chk(tri_o, p);
      ntc <= 1'b0;
      tick(6);
      chk(tt_n, 1'b1);
      tgt <= 7'h44;
      flt <= 5'h01;
      tick(3 + xs() % 12);
      flt <= 5'h00;
      tick(6);
      bus(1'b0, 4'h4, 32'h0);
      chk(r[11:7], 5'h00);
      for (k = 0; k < 5; k++)
      begin
         flt <= 5'(1 << k);
         tick(60);
         flt <= 5'h00;
         tick(2);
         chk(tri_o, 1'b1);
         chk(pg, 1'b0);
         bus(1'b0, 4'h4, 32'h0);
         chk(r[11:7], 1 << k);
         en <= 1'b0;
         tick(6);
         en <= 1'b1;
         tick(10);
         bus(1'b0, 4'h4, 32'h0);
         chk(r[11:7], 5'h00);
      end
      $display("latched faults done");
      for (k = 0; k < 2; k++)
      begin
         ova_hi <= 1'b1;
         tick(3);
         ova_hi <= 1'b0;
         tick(20);
         chk(lsf, 1'b1);
         chk(pg, 1'b0);
         ova_lo <= 1'b1;
         tick(5);
         ova_lo <= 1'b0;
         chk(lsf, 1'b0);
         chk(tri_o, 1'b1);
      end
      en <= 1'b0;
      tick(6);
      en <= 1'b1;
      tick(10);
      bus(1'b0, 4'h4, 32'h0);
      chk(r[12], 1'b1);
      sup <= 1'b0;
      tick(6);
      sup <= 1'b1;
      tick(10);
      bus(1'b0, 4'h4, 32'h0);
      chk(r[12], 1'b0);
      $display("absolute overvoltage done");
      tick(18000);
      chk(dac, 12'h6a4);
      $display("reference ramp done");
      end_sim();
   end
endmodule
